// >>> verilog/uv_otp_pkg.sv
package uv_otp_pkg;
  // ==========================================
  // Clock and undervoltage timing
  localparam longint unsigned CLK_HZ = 64'd100_000_000;
  localparam longint unsigned UV_HOLD_S = 64'd15;
  localparam int unsigned UV_HOLD_CYCLES = int'(UV_HOLD_S * CLK_HZ);
  localparam int UV_CNT_W = 31;

  // ==========================================
  // Nonvolatile store layout
  localparam int OTP_BYTES = 8;
  localparam logic [2:0] ADDR_OSCILLATOR_REFERENCE_TRIM = 3'h0;
  localparam logic [2:0] ADDR_BUS_TRIM = 3'h1;
  localparam logic [2:0] ADDR_THR_NODE = 3'h2;
  localparam logic [2:0] ADDR_CURRENT = 3'h3;
  localparam logic [2:0] ADDR_VELOCITY = 3'h4;
  localparam logic [2:0] ADDR_SAFE_HI = 3'h5;
  localparam logic [2:0] ADDR_SAFE_LO = 3'h6;
  localparam logic [2:0] ADDR_LOCKS = 3'h7;
  localparam logic [2:0] FACTORY_LAST_ADDR = 3'h1;
  localparam int USER_LOCK_BIT = 0;
  localparam int FACTORY_LOCK_BIT = 1;
  localparam int STEP_MODE_LSB = 2;
  localparam int SAFE_HI_LSB = 5;
  localparam int SAFE_LO_LSB = 2;
  localparam logic [7:0] NODE_ADDR_MASK = 8'h0f;

  // Delivery image; arbitrary values except the factory lock
  localparam logic [7:0] FACTORY_IMAGE [OTP_BYTES] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};

  // ==========================================
  // Parameter encodings
  localparam logic [12:0] ABS_THR_STEP_MV = 13'h1f4;
  localparam logic [12:0] DEL_THR_STEP_MV = 13'h0fa;
  localparam logic [9:0] RUN_CURRENT_MA [16] = '{
    10'h03b, 10'h047, 10'h054, 10'h064, 10'h077, 10'h08d, 10'h0a8, 10'h0c8,
    10'h0ee, 10'h11b, 10'h150, 10'h190, 10'h1dc, 10'h236, 10'h2a1, 10'h320};
  localparam logic [4:0] MICROSTEPS [4] = '{5'h02, 5'h04, 5'h08, 5'h10};

  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_HARD_UNDER,
    ST_SHUT_UNDER,
    ST_SHUTDOWN
  } uv_state_t;
endpackage : uv_otp_pkg

// >>> verilog/level_sync3.sv
module level_sync3 (
  input wire logic clk,
  input wire logic srst,
  input wire logic i_async,
  output logic o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ==========================================
  // Three stages; change accepted when stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end
endmodule : level_sync3

// >>> verilog/otp_byte_cell.sv
module otp_byte_cell (
  input wire logic clk,
  input wire logic i_init,
  input wire logic [7:0] i_init_value,
  input wire logic i_zap,
  input wire logic [7:0] i_zap_bits,
  output logic [7:0] o_value
);
  // ==========================================
  // Survives logic reset; zapping only ever adds ones
  always_ff @(posedge clk) begin
    if (i_init) begin
      o_value <= i_init_value;
    end else if (i_zap) begin
      o_value <= o_value | i_zap_bits;
    end
  end
endmodule : otp_byte_cell

// >>> verilog/undervoltage_otp_control.sv
module undervoltage_otp_control #(
  parameter int unsigned UV_HOLD_CYCLES = uv_otp_pkg::UV_HOLD_CYCLES
) (
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  input wire logic I_OTP_INIT,
  input wire logic I_VBB_BELOW_DEEP,
  input wire logic I_VBB_ABOVE_RECOVERY,
  input wire logic I_PUMP_OK,
  input wire logic I_STATUS_READ_CMD,
  input wire logic I_FULL_STATUS_READ_CMD,
  input wire logic I_POSITION_WRITE_CMD,
  input wire logic I_SHORT_POSITION_WRITE_CMD,
  input wire logic I_POSITION_PARAM_CMD,
  input wire logic I_SAFE_POSITION_CMD,
  input wire logic I_DUAL_POSITION_CMD,
  input wire logic [15:0] I_CMD_POSITION,
  input wire logic [15:0] I_ACTUAL_POSITION,
  input wire logic I_MOTOR_PARAM_WRITE_CMD,
  input wire logic [2:0] I_PARAM_ADDR,
  input wire logic [7:0] I_PARAM_DATA,
  input wire logic I_OTP_BYTE_PROGRAM_CMD,
  input wire logic I_OTP_BYTE_READ_CMD,
  input wire logic [2:0] I_HARDWIRED_ADDRESS_BITS,
  output uv_otp_pkg::uv_state_t O_UV_STATE,
  output logic O_MOTION_EN,
  output logic O_MOTOR_HIZ,
  output logic O_DEEP_UNDERVOLTAGE_FLAG,
  output logic O_MISSED_STEP_FLAG,
  output logic O_PUMP_FAILURE_FLAG,
  output logic [15:0] O_TARGET_POSITION,
  output logic O_DUAL_POSITION_GO,
  output logic [15:0] O_DUAL_POSITION,
  output logic [7:0] O_OTP_READ_DATA,
  output logic O_OTP_READ_VALID,
  output logic O_OTP_PROGRAM_DONE,
  output logic O_OTP_PROGRAM_REFUSED,
  output logic [6:0] O_NODE_ADDRESS,
  output logic O_ABS_DETECT_EN,
  output logic [12:0] O_ABS_THRESHOLD_MV,
  output logic O_REL_DETECT_EN,
  output logic [12:0] O_REL_THRESHOLD_MV,
  output logic [9:0] O_RUN_CURRENT_MA,
  output logic [3:0] O_HOLD_CURRENT_CODE,
  output logic [10:0] O_SAFE_POSITION_VALUE,
  output logic [4:0] O_MICROSTEP_RESOLUTION,
  output logic O_LOW_POWER_ALLOW_BIT,
  output logic O_BUS_INTERFACE_ENABLE_BIT
);
  import uv_otp_pkg::*;

  // ==========================================
  // Pump sensed as failure so a freshly reset synchroniser reads healthy
  logic deep_uv;
  logic recovered;
  logic pump_fail;

  level_sync3 u_sync_deep (
    .clk(I_REF_CLK),
    .srst(I_SRST),
    .i_async(I_VBB_BELOW_DEEP),
    .o_level(deep_uv)
  );

  level_sync3 u_sync_recov (
    .clk(I_REF_CLK),
    .srst(I_SRST),
    .i_async(I_VBB_ABOVE_RECOVERY),
    .o_level(recovered)
  );

  level_sync3 u_sync_pump (
    .clk(I_REF_CLK),
    .srst(I_SRST),
    .i_async(~I_PUMP_OK),
    .o_level(pump_fail)
  );

  logic status_cmd;
  logic pos_cmd;
  assign status_cmd = I_STATUS_READ_CMD | I_FULL_STATUS_READ_CMD;
  assign pos_cmd = I_POSITION_WRITE_CMD | I_SHORT_POSITION_WRITE_CMD |
                   I_POSITION_PARAM_CMD | I_SAFE_POSITION_CMD;

  // ==========================================
  // Undervoltage state machine
  uv_state_t state_q;
  uv_state_t state_d;
  logic [UV_CNT_W-1:0] hold_cnt_q;
  logic hold_expired;
  logic trigger;

  assign trigger = deep_uv | pump_fail;
  assign hold_expired = (hold_cnt_q >= UV_HOLD_CYCLES[UV_CNT_W-1:0]);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_ACTIVE: begin
        if (trigger) begin
          state_d = ST_HARD_UNDER;
        end
      end
      ST_HARD_UNDER: begin
        state_d = ST_SHUT_UNDER;
      end
      ST_SHUT_UNDER: begin
        if (hold_expired) begin
          state_d = ST_SHUTDOWN;
        end else if (recovered && !deep_uv && !pump_fail) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_SHUTDOWN: begin
        if (recovered && !pump_fail && status_cmd) begin
          state_d = ST_ACTIVE;
        end
      end
    endcase
  end

  // Logic reset is the only way out of every state besides the machine
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      state_q <= ST_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // Hold time counts only while waiting for recovery
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST || state_q != ST_SHUT_UNDER || state_d == ST_ACTIVE) begin
      hold_cnt_q <= '0;
    end else if (!hold_expired) begin
      hold_cnt_q <= hold_cnt_q + 1'b1;
    end
  end

  assign O_UV_STATE = state_q;
  assign O_MOTION_EN = (state_q == ST_ACTIVE);
  assign O_MOTOR_HIZ = (state_q != ST_ACTIVE);

  // ==========================================
  // Flags; a new event wins over a clearing status read
  logic deep_flag_q;
  logic step_flag_q;
  logic pump_flag_q;
  logic uv_entry;
  assign uv_entry = (state_q == ST_ACTIVE) && trigger;

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      deep_flag_q <= 1'b0;
      step_flag_q <= 1'b0;
    end else if (uv_entry) begin
      deep_flag_q <= 1'b1;
      step_flag_q <= 1'b1;
    end else if (status_cmd && recovered) begin
      deep_flag_q <= 1'b0;
      step_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      pump_flag_q <= 1'b0;
    end else if (pump_fail) begin
      pump_flag_q <= 1'b1;
    end else if (status_cmd) begin
      pump_flag_q <= 1'b0;
    end
  end

  assign O_DEEP_UNDERVOLTAGE_FLAG = deep_flag_q;
  assign O_MISSED_STEP_FLAG = step_flag_q;
  assign O_PUMP_FAILURE_FLAG = pump_flag_q;

  // ==========================================
  // Target position and deferred dual position
  logic [15:0] target_q;
  logic dual_pend_q;
  logic [15:0] dual_pos_q;
  logic flags_clear;
  assign flags_clear = ~deep_flag_q & ~step_flag_q & ~pump_flag_q;

  // Target is untouched on entry; outside ST_ACTIVE only expiry overwrites it
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      target_q <= '0;
    end else if (state_q == ST_SHUT_UNDER && hold_expired) begin
      target_q <= I_ACTUAL_POSITION;
    end else if (state_q == ST_ACTIVE && pos_cmd) begin
      target_q <= I_CMD_POSITION;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      dual_pend_q <= 1'b0;
      dual_pos_q <= '0;
      O_DUAL_POSITION_GO <= 1'b0;
    end else begin
      O_DUAL_POSITION_GO <= 1'b0;
      if (I_DUAL_POSITION_CMD) begin
        dual_pend_q <= 1'b1;
        dual_pos_q <= I_CMD_POSITION;
      end else if (dual_pend_q && flags_clear && state_q == ST_ACTIVE) begin
        dual_pend_q <= 1'b0;
        O_DUAL_POSITION_GO <= 1'b1;
      end
    end
  end

  assign O_TARGET_POSITION = target_q;
  assign O_DUAL_POSITION = dual_pos_q;

  // ==========================================
  // Nonvolatile store, one cell per byte
  logic [7:0] otp_val [OTP_BYTES];
  logic [7:0] zap_en;
  logic prog_locked;
  logic prog_rezap;
  logic prog_ok;
  logic [7:0] sel_byte;
  logic [7:0] locks;

  assign sel_byte = otp_val[I_PARAM_ADDR];
  assign locks = otp_val[ADDR_LOCKS];
  // Locks act at once, unlike parameters, so a locked part stays locked
  assign prog_locked = locks[USER_LOCK_BIT] ||
      (locks[FACTORY_LOCK_BIT] && I_PARAM_ADDR <= FACTORY_LAST_ADDR);
  assign prog_rezap = |(sel_byte & I_PARAM_DATA);
  assign prog_ok = I_OTP_BYTE_PROGRAM_CMD && !prog_locked && !prog_rezap;

  genvar gi;
  generate
    for (gi = 0; gi < OTP_BYTES; gi++) begin : g_otp
      assign zap_en[gi] = prog_ok && (I_PARAM_ADDR == 3'(gi));
      otp_byte_cell u_cell (
        .clk(I_REF_CLK),
        .i_init(I_OTP_INIT),
        .i_init_value(FACTORY_IMAGE[gi]),
        .i_zap(zap_en[gi]),
        .i_zap_bits(I_PARAM_DATA),
        .o_value(otp_val[gi])
      );
    end
  endgenerate

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_OTP_PROGRAM_DONE <= 1'b0;
      O_OTP_PROGRAM_REFUSED <= 1'b0;
      O_OTP_READ_VALID <= 1'b0;
      O_OTP_READ_DATA <= '0;
    end else begin
      O_OTP_PROGRAM_DONE <= prog_ok;
      O_OTP_PROGRAM_REFUSED <= I_OTP_BYTE_PROGRAM_CMD && !prog_ok;
      O_OTP_READ_VALID <= I_OTP_BYTE_READ_CMD;
      if (I_OTP_BYTE_READ_CMD) begin
        O_OTP_READ_DATA <= sel_byte;
      end
    end
  end

  // ==========================================
  // RAM copies; loaded once after logic reset
  logic [7:0] ram_q [OTP_BYTES];
  logic load_q;

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      load_q <= 1'b1;
    end else begin
      load_q <= 1'b0;
    end
  end

  // New zaps are not seen until the next reset reload
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      for (int i = 0; i < OTP_BYTES; i++) begin
        ram_q[i] <= '0;
      end
    end else if (load_q) begin
      for (int i = 0; i < OTP_BYTES; i++) begin
        ram_q[i] <= otp_val[i];
      end
    end else if (I_MOTOR_PARAM_WRITE_CMD && I_PARAM_ADDR > FACTORY_LAST_ADDR) begin
      if (I_PARAM_ADDR == ADDR_THR_NODE) begin
        ram_q[ADDR_THR_NODE] <= (I_PARAM_DATA & ~NODE_ADDR_MASK) |
                                (ram_q[ADDR_THR_NODE] & NODE_ADDR_MASK);
      end else begin
        ram_q[I_PARAM_ADDR] <= I_PARAM_DATA;
      end
    end
  end

  // ==========================================
  // Decoded parameters
  logic [3:0] abs_code;
  logic [3:0] rel_code;
  assign abs_code = ram_q[ADDR_THR_NODE][7:4];
  assign rel_code = ram_q[ADDR_LOCKS][7:4];

  assign O_NODE_ADDRESS = {ram_q[ADDR_THR_NODE][3:0], I_HARDWIRED_ADDRESS_BITS};
  assign O_ABS_DETECT_EN = (abs_code != 4'h0);
  assign O_ABS_THRESHOLD_MV = 13'(abs_code * ABS_THR_STEP_MV);
  assign O_REL_DETECT_EN = (rel_code != 4'h0);
  assign O_REL_THRESHOLD_MV = 13'(rel_code * DEL_THR_STEP_MV);
  assign O_RUN_CURRENT_MA = RUN_CURRENT_MA[ram_q[ADDR_CURRENT][7:4]];
  assign O_HOLD_CURRENT_CODE = ram_q[ADDR_CURRENT][3:0];
  assign O_SAFE_POSITION_VALUE = {ram_q[ADDR_SAFE_HI][7:SAFE_HI_LSB],
                                  ram_q[ADDR_SAFE_LO][7:SAFE_LO_LSB], 2'b00};
  assign O_MICROSTEP_RESOLUTION =
      MICROSTEPS[ram_q[ADDR_LOCKS][STEP_MODE_LSB+1:STEP_MODE_LSB]];
  assign O_LOW_POWER_ALLOW_BIT = ram_q[ADDR_SAFE_LO][0];
  // Bus enable only changes on reload, so a fresh zap cannot cut the link
  assign O_BUS_INTERFACE_ENABLE_BIT = ram_q[ADDR_BUS_TRIM][7];
endmodule : undervoltage_otp_control

// >>> testbench/undervoltage_otp_control_checker.sv
module undervoltage_otp_control_checker
  import uv_otp_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  input wire logic I_STATUS_READ_CMD,
  input wire logic I_FULL_STATUS_READ_CMD,
  input wire logic [15:0] I_ACTUAL_POSITION,
  input wire logic I_OTP_BYTE_PROGRAM_CMD,
  input wire logic I_OTP_BYTE_READ_CMD,
  input wire logic [2:0] I_HARDWIRED_ADDRESS_BITS,
  input wire uv_state_t O_UV_STATE,
  input wire logic O_MOTION_EN,
  input wire logic O_MOTOR_HIZ,
  input wire logic O_DEEP_UNDERVOLTAGE_FLAG,
  input wire logic O_MISSED_STEP_FLAG,
  input wire logic O_PUMP_FAILURE_FLAG,
  input wire logic [15:0] O_TARGET_POSITION,
  input wire logic O_DUAL_POSITION_GO,
  input wire logic O_OTP_READ_VALID,
  input wire logic O_OTP_PROGRAM_DONE,
  input wire logic O_OTP_PROGRAM_REFUSED,
  input wire logic [6:0] O_NODE_ADDRESS,
  input wire logic O_ABS_DETECT_EN,
  input wire logic [12:0] O_ABS_THRESHOLD_MV
);
  // ======
  // Undervoltage states
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_SRST);
  entry_flags_a: assert property (
    $past(O_UV_STATE) == ST_ACTIVE && O_UV_STATE == ST_HARD_UNDER
    |-> O_DEEP_UNDERVOLTAGE_FLAG && O_MISSED_STEP_FLAG) else $error("entry flags missing");
  hard_to_shut_a: assert property (
    O_UV_STATE == ST_HARD_UNDER |=> O_UV_STATE == ST_SHUT_UNDER) else $error("no shut state");
  target_kept_a: assert property (
    $past(O_UV_STATE) == ST_SHUT_UNDER && O_UV_STATE == ST_SHUT_UNDER
    |-> $stable(O_TARGET_POSITION)) else $error("target moved");
  shutdown_copy_a: assert property (
    $past(O_UV_STATE) == ST_SHUT_UNDER && O_UV_STATE == ST_SHUTDOWN
    |-> O_TARGET_POSITION == $past(I_ACTUAL_POSITION)) else $error("target not copied");
  shutdown_hold_a: assert property (
    O_UV_STATE == ST_SHUTDOWN && !I_STATUS_READ_CMD && !I_FULL_STATUS_READ_CMD
    |=> O_UV_STATE == ST_SHUTDOWN) else $error("shutdown left early");
  hiz_follows_a: assert property (
    O_MOTION_EN == (O_UV_STATE == ST_ACTIVE) && O_MOTOR_HIZ == !O_MOTION_EN)
    else $error("drive state wrong");
  flag_clear_a: assert property (
    $fell(O_DEEP_UNDERVOLTAGE_FLAG) |-> $past(I_STATUS_READ_CMD) || $past(I_FULL_STATUS_READ_CMD))
    else $error("flag cleared without read");
  dual_gate_a: assert property (
    O_DUAL_POSITION_GO |-> !$past(O_DEEP_UNDERVOLTAGE_FLAG) && !$past(O_MISSED_STEP_FLAG)
    && !$past(O_PUMP_FAILURE_FLAG)) else $error("dual ran with flags");
  // ======
  // Store and decodes
  program_answer_a: assert property (
    I_OTP_BYTE_PROGRAM_CMD |=> O_OTP_PROGRAM_DONE != O_OTP_PROGRAM_REFUSED)
    else $error("program answer wrong");
  read_answer_a: assert property (
    O_OTP_READ_VALID == $past(I_OTP_BYTE_READ_CMD)) else $error("read answer wrong");
  node_low_a: assert property (
    O_NODE_ADDRESS[2:0] == I_HARDWIRED_ADDRESS_BITS) else $error("node address wrong");
  abs_enable_a: assert property (
    O_ABS_DETECT_EN == (O_ABS_THRESHOLD_MV != 13'h0)) else $error("abs enable wrong");
  shutdown_c: cover property (O_UV_STATE == ST_SHUTDOWN);
  refused_c: cover property (O_OTP_PROGRAM_REFUSED);
  dual_go_c: cover property (O_DUAL_POSITION_GO);
endmodule : undervoltage_otp_control_checker

bind undervoltage_otp_control undervoltage_otp_control_checker checker_inst (
  .I_REF_CLK, .I_SRST, .I_STATUS_READ_CMD, .I_FULL_STATUS_READ_CMD, .I_ACTUAL_POSITION,
  .I_OTP_BYTE_PROGRAM_CMD, .I_OTP_BYTE_READ_CMD, .I_HARDWIRED_ADDRESS_BITS, .O_UV_STATE,
  .O_MOTION_EN, .O_MOTOR_HIZ, .O_DEEP_UNDERVOLTAGE_FLAG, .O_MISSED_STEP_FLAG,
  .O_PUMP_FAILURE_FLAG, .O_TARGET_POSITION, .O_DUAL_POSITION_GO, .O_OTP_READ_VALID,
  .O_OTP_PROGRAM_DONE, .O_OTP_PROGRAM_REFUSED, .O_NODE_ADDRESS, .O_ABS_DETECT_EN,
  .O_ABS_THRESHOLD_MV);

// >>> testbench/lin_master_model.sv
module lin_master_model (
  input wire logic clk,
  output logic [9:0] o_strb,
  output logic [2:0] o_addr,
  output logic [7:0] o_data,
  output logic [15:0] o_pos
);
  timeunit 1ns;
  timeprecision 1ns;
  // ======
  // Command slots; idle fields inverted so stale data never looks valid
  initial begin
    o_strb = 10'h0;
    o_addr = 3'h0;
    o_data = 8'h0;
    o_pos = 16'h0;
  end
  task automatic send(input int k, input logic [2:0] a, input logic [7:0] d,
                      input logic [15:0] p);
    @(posedge clk);
    o_strb[k] <= 1'b1;
    o_addr <= a;
    o_data <= d;
    o_pos <= p;
    @(posedge clk);
    o_strb <= 10'h0;
    o_addr <= ~a;
    o_data <= ~d;
    o_pos <= ~p;
  endtask : send
endmodule : lin_master_model

// >>> testbench/undervoltage_otp_control_tb.sv
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected %0t got %0h want %0h", $time, a, b); end end
module undervoltage_otp_control_tb;
  import uv_otp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD = 50;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic init = 1'b1;
  logic deep = 1'b0, rec = 1'b1, pump = 1'b1;
  logic [15:0] act = 16'h0;
  logic [2:0] hw = 3'h5;
  logic [9:0] strb;
  logic [2:0] addr;
  logic [7:0] data, rdat;
  logic [15:0] pos, tgt, dpos;
  uv_state_t st;
  logic men, hiz, fdeep, fstep, fpump, dgo, rdv, pdone, pref, absen, relen, lpa, bie;
  logic [6:0] nad;
  logic [12:0] absmv, relmv;
  logic [9:0] irun;
  logic [3:0] ihold;
  logic [10:0] safe;
  logic [4:0] mstep;
  logic [7:0] otp_m [8];
  logic [7:0] ram_m [8];
  logic [31:0] c;
  int seed = 32'h95bd;
  int compares = 0;
  int fail_count = 0;
  int n;
  lin_master_model lin_master_model_inst (.clk(clk), .o_strb(strb), .o_addr(addr),
    .o_data(data), .o_pos(pos));
  undervoltage_otp_control #(.UV_HOLD_CYCLES(HOLD)) undervoltage_otp_control_inst (
    .I_REF_CLK(clk), .I_SRST(srst), .I_OTP_INIT(init), .I_VBB_BELOW_DEEP(deep),
    .I_VBB_ABOVE_RECOVERY(rec), .I_PUMP_OK(pump), .I_STATUS_READ_CMD(strb[0]),
    .I_FULL_STATUS_READ_CMD(strb[1]), .I_POSITION_WRITE_CMD(strb[2]),
    .I_SHORT_POSITION_WRITE_CMD(strb[3]), .I_POSITION_PARAM_CMD(strb[4]),
    .I_SAFE_POSITION_CMD(strb[5]), .I_DUAL_POSITION_CMD(strb[6]), .I_CMD_POSITION(pos),
    .I_ACTUAL_POSITION(act), .I_MOTOR_PARAM_WRITE_CMD(strb[7]), .I_PARAM_ADDR(addr),
    .I_PARAM_DATA(data), .I_OTP_BYTE_PROGRAM_CMD(strb[8]), .I_OTP_BYTE_READ_CMD(strb[9]),
    .I_HARDWIRED_ADDRESS_BITS(hw), .O_UV_STATE(st), .O_MOTION_EN(men), .O_MOTOR_HIZ(hiz),
    .O_DEEP_UNDERVOLTAGE_FLAG(fdeep), .O_MISSED_STEP_FLAG(fstep), .O_PUMP_FAILURE_FLAG(fpump),
    .O_TARGET_POSITION(tgt), .O_DUAL_POSITION_GO(dgo), .O_DUAL_POSITION(dpos),
    .O_OTP_READ_DATA(rdat), .O_OTP_READ_VALID(rdv), .O_OTP_PROGRAM_DONE(pdone),
    .O_OTP_PROGRAM_REFUSED(pref), .O_NODE_ADDRESS(nad), .O_ABS_DETECT_EN(absen),
    .O_ABS_THRESHOLD_MV(absmv), .O_REL_DETECT_EN(relen), .O_REL_THRESHOLD_MV(relmv),
    .O_RUN_CURRENT_MA(irun), .O_HOLD_CURRENT_CODE(ihold), .O_SAFE_POSITION_VALUE(safe),
    .O_MICROSTEP_RESOLUTION(mstep), .O_LOW_POWER_ALLOW_BIT(lpa),
    .O_BUS_INTERFACE_ENABLE_BIT(bie));
  // ======
  // Clock, watchdog, verdict
  always #5 clk = ~clk;
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  // ======
  // Model tasks
  task automatic rst();
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    init <= 1'b0;
    ram_m = otp_m;
    repeat (2) @(posedge clk);
    #1;
  endtask : rst
  task automatic pins(input logic d, input logic r, input logic p);
    @(posedge clk);
    deep <= d;
    rec <= r;
    pump <= p;
  endtask : pins
  task automatic chk_dec();
    `CHK(absmv, ram_m[2][7:4] * ABS_THR_STEP_MV)
    `CHK(absen, ram_m[2][7:4] != 4'h0)
    `CHK(relmv, ram_m[7][7:4] * DEL_THR_STEP_MV)
    `CHK(relen, ram_m[7][7:4] != 4'h0)
    `CHK(irun, RUN_CURRENT_MA[ram_m[3][7:4]])
    `CHK(ihold, ram_m[3][3:0])
    `CHK(mstep, 5'h02 << ram_m[7][3:2])
    `CHK(safe, {ram_m[5][7:5], ram_m[6][7:2], 2'h0})
    `CHK(nad, {ram_m[2][3:0], hw})
    `CHK({lpa, bie}, {ram_m[6][0], ram_m[1][7]})
  endtask : chk_dec
  task automatic prog(input logic [2:0] a, input logic [7:0] d);
    logic bad;
    bad = otp_m[7][0] || (otp_m[7][1] && a <= FACTORY_LAST_ADDR) || (otp_m[a] & d) != 8'h0;
    lin_master_model_inst.send(8, a, d, 16'h0);
    #1;
    `CHK(pref, bad)
    `CHK(pdone, !bad)
    otp_m[a] |= bad ? 8'h0 : d;
    lin_master_model_inst.send(9, a, 8'h0, 16'h0);
    #1;
    `CHK({rdv, rdat}, {1'b1, otp_m[a]})
  endtask : prog
  task automatic mpw(input logic [2:0] a, input logic [7:0] d);
    lin_master_model_inst.send(7, a, d, 16'h0);
    if (a > 3'h1) ram_m[a] = (a == 3'h2) ? {d[7:4], ram_m[2][3:0]} : d;
    #1;
    chk_dec();
  endtask : mpw
  task automatic wait_st(input uv_state_t s, input int lim);
    n = 0;
    while (st !== s && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(st, s)
  endtask : wait_st
  task automatic cmd(input int k, input logic [15:0] p);
    lin_master_model_inst.send(k, 3'h0, 8'h0, p);
    #1;
  endtask : cmd
  // ======
  // Tests
  initial begin
    foreach (otp_m[i]) otp_m[i] = FACTORY_IMAGE[i];
    rst();
    chk_dec();
    `CHK({st, fdeep, fstep, fpump}, {ST_ACTIVE, 3'h0})
    $display("test reset done");
    c = $random(seed);
    prog(3'h0, 8'h01);
    foreach (c[i]) if (i % 8 == 0) prog(3'h2 + 3'(i / 8), c[i +: 8]);
    prog(3'h6, c[11:4]);
    prog(3'h7, {c[27:24], c[1:0], 2'h0});
    prog(3'h2, 8'hff);
    chk_dec();
    @(posedge clk);
    rst();
    chk_dec();
    mpw(3'h3, ~c[7:0]);
    mpw(3'h2, 8'h3c);
    mpw(3'h0, 8'hff);
    $display("test store done");
    cmd(2, c[15:0]);
    `CHK(tgt, c[15:0])
    pins(1'b1, 1'b0, 1'b1);
    wait_st(ST_SHUT_UNDER, 20);
    `CHK({fdeep, fstep, hiz, men}, 4'he)
    for (int k = 2; k < 6; k++) cmd(k, ~c[15:0]);
    `CHK(tgt, c[15:0])
    pins(1'b0, 1'b1, 1'b1);
    wait_st(ST_ACTIVE, 20);
    `CHK({fdeep, fstep}, 2'h3)
    cmd(2, c[31:16]);
    `CHK(tgt, c[31:16])
    cmd(6, ~c[31:16]);
    repeat (3) @(posedge clk);
    #1;
    `CHK(dgo, 1'b0)
    cmd(0, 16'h0);
    `CHK({fdeep, fstep}, 2'h0)
    @(posedge clk);
    #1;
    `CHK({dgo, dpos}, {1'b1, ~c[31:16]})
    $display("test recovery done");
    pins(1'b0, 1'b1, 1'b0);
    act <= c[23:8];
    wait_st(ST_SHUT_UNDER, 20);
    `CHK(fpump, 1'b1)
    wait_st(ST_SHUTDOWN, HOLD + 10);
    `CHK(n >= HOLD - 1 && n <= HOLD + 1, 1'b1)
    `CHK(tgt, c[23:8])
    cmd(0, 16'h0);
    `CHK({st, fpump}, {ST_SHUTDOWN, 1'b1})
    pins(1'b0, 1'b1, 1'b1);
    repeat (8) @(posedge clk);
    #1;
    `CHK(st, ST_SHUTDOWN)
    cmd(1, 16'h0);
    wait_st(ST_ACTIVE, 3);
    `CHK({fdeep, fpump}, 2'h0)
    $display("test shutdown done");
    prog(3'h7, 8'h01);
    prog(3'h4, 8'h11);
    pins(1'b1, 1'b1, 1'b1);
    wait_st(ST_SHUT_UNDER, 20);
    pins(1'b0, 1'b1, 1'b1);
    rst();
    `CHK({st, fdeep, fstep}, {ST_ACTIVE, 2'h0})
    $display("test lock and reset done");
    print_verdict();
  end
endmodule : undervoltage_otp_control_tb
